// ===== srcm_defs.vh
// Constants for the reference capture and margin monitor block
// Assumes inclusion by bare name from the block's design file
`ifndef SRCM_DEFS_VH
`define SRCM_DEFS_VH

// Register indices; byte address is four times the index
`define SRCM_IDX_CTRL 10'h120
`define SRCM_IDX_SKIP 10'h121
`define SRCM_IDX_MARGIN 10'h128
`define SRCM_IDX_IRQ_STAT 10'h130
`define SRCM_IDX_IRQ_MASK 10'h131
`define SRCM_IDX_QCFG 10'h132
`define SRCM_IDX_KFRM 10'h133
`define SRCM_IDX_STATUS 10'h134
`define SRCM_IDX_LINK 10'h135

// Control register fields
`define SRCM_CTRL_FALL_POL 0
`define SRCM_CTRL_NEG_EDGE 1
`define SRCM_CTRL_CONT 2
`define SRCM_CTRL_ALN_DIV 3
`define SRCM_CTRL_ALN_DNC 4
`define SRCM_CTRL_ALN_MON 5
`define SRCM_CTRL_ALN_LNK 6
`define SRCM_CTRL_LOW_RATE 7
`define SRCM_CTRL_RST 8'h78

// Application mode in link register bit 0: 0 eight-converter complex,
// 1 noise shaping requantizer
`define SRCM_LINK_REQ 0

// Interrupt status bits
`define SRCM_IRQ_ALIGN 0
`define SRCM_IRQ_VIOL 1
`define SRCM_IRQ_QERR 2

// Skip count limit and reset values
`define SRCM_SKIP_MAX 5'h10
`define SRCM_KFRM_RST 6'h20
`define SRCM_QCFG_RST 8'h1c

// Quick configuration codes
`define SRCM_Q_L1M8F16 8'h1c
`define SRCM_Q_L2M8F8 8'h5b
`define SRCM_Q_L2M2F2 8'h49
`define SRCM_Q_L4M2F1 8'h88

// Sample format
`define SRCM_NP_BITS 5'h10
`define SRCM_N_CPLX 5'h0e
`define SRCM_N_REQ 5'h09
`define SRCM_M_CPLX 4'h8
`define SRCM_M_REQ 4'h2

// Margin nibble layout and boundary values
`define SRCM_NIB_MID 4'h8
`define SRCM_NIB_ZERO 4'h0

`endif

// ===== srcm_top.v
// Reference (SYSREF) capture, skip, alignment and margin monitor
// Assumes sysref_i and the tap levels are synchronous to clk_i,
// the sample clock, and a classic Wishbone master on the bus side
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "srcm_defs.vh"

module srcm_top #(
  parameter TAPS = 15
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire [11:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Reference input and detector taps
  input wire sysref_i,
  input wire [TAPS-1:0] setup_taps_i,
  input wire [TAPS-1:0] hold_taps_i,
  // Alignment strobes
  output reg align_clkdiv_o,
  output reg align_downconv_o,
  output reg align_sigmon_o,
  output reg align_framer_o,
  // Link configuration
  output reg [2:0] lanes_o,
  output reg [3:0] converters_o,
  output reg [4:0] octets_o,
  output reg [4:0] res_bits_o,
  output reg [4:0] container_bits_o,
  output reg [5:0] frames_per_mf_o,
  output reg low_lane_rate_o,
  // Interrupt
  output reg irq_o
);

  // Register state
  reg [7:0] ctrl_r;
  reg [4:0] skip_cfg_r;
  reg [7:0] margin_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [7:0] qcfg_r;
  reg [5:0] kfrm_r;
  reg link_req_r;
  reg [4:0] skip_left_r;
  reg armed_r;
  reg [1:0] class_r;

  // Capture path
  reg neg_samp_r;
  reg samp_r;
  reg prev_r;
  reg [TAPS-1:0] setup_q_r;
  reg [TAPS-1:0] hold_q_r;

  // Bus decode
  wire [9:0] idx = adr_i[11:2];
  wire req = cyc_i & stb_i;
  wire wr = req & we_i & ack_o & sel_i[0];

  // Per-register write strobes, taken at the acknowledge edge
  wire wr_ctrl = wr && (idx == `SRCM_IDX_CTRL);
  wire wr_skip = wr && (idx == `SRCM_IDX_SKIP);
  wire wr_irq_stat = wr && (idx == `SRCM_IDX_IRQ_STAT);
  wire wr_irq_mask = wr && (idx == `SRCM_IDX_IRQ_MASK);
  wire wr_qcfg = wr && (idx == `SRCM_IDX_QCFG);
  wire wr_kfrm = wr && (idx == `SRCM_IDX_KFRM);
  wire wr_link = wr && (idx == `SRCM_IDX_LINK);

  // Skip count clipped to the largest legal value
  wire skip_big = dat_i[4:0] > `SRCM_SKIP_MAX;
  wire [4:0] skip_clip = skip_big ? `SRCM_SKIP_MAX : dat_i[4:0];

  // Falling edge sample taken half a cycle early, retimed below
  always @(negedge clk_i) begin
    neg_samp_r <= sysref_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      samp_r <= 1'b0;
      prev_r <= 1'b0;
      setup_q_r <= {TAPS{1'b0}};
      hold_q_r <= {TAPS{1'b0}};
    end else begin
      samp_r <= ctrl_r[`SRCM_CTRL_NEG_EDGE] ? neg_samp_r : sysref_i;
      prev_r <= samp_r;
      setup_q_r <= setup_taps_i;
      hold_q_r <= hold_taps_i;
    end
  end

  // Event detect on chosen transition
  wire fall_pol = ctrl_r[`SRCM_CTRL_FALL_POL];
  wire ev = fall_pol ? (prev_r & ~samp_r) : (~prev_r & samp_r);
  wire accept = ev & armed_r & (skip_left_r == 5'h00);
  wire discard = ev & armed_r & (skip_left_r != 5'h00);

  // Per-tap flags: tap already shows the post-event level
  wire [TAPS-1:0] setup_hit;
  wire [TAPS-1:0] hold_hit;
  genvar g;
  generate
    for (g = 0; g < TAPS; g = g + 1) begin : g_tap
      assign setup_hit[g] = setup_q_r[g] ^ fall_pol;
      assign hold_hit[g] = hold_q_r[g] ^ fall_pol;
    end
  endgenerate

  // Count the flagged taps
  reg [3:0] setup_cnt;
  reg [3:0] hold_cnt;
  integer i;
  always @* begin
    setup_cnt = 4'h0;
    hold_cnt = 4'h0;
    for (i = 0; i < TAPS; i = i + 1) begin
      setup_cnt = setup_cnt + {3'h0, setup_hit[i]};
      hold_cnt = hold_cnt + {3'h0, hold_hit[i]};
    end
  end

  // Margin class codes
  localparam [1:0] CLS_OK = 2'b00;
  localparam [1:0] CLS_SETUP = 2'b01;
  localparam [1:0] CLS_HOLD = 2'b10;
  localparam [1:0] CLS_BOTH = 2'b11;

  // Margin classification of the held status byte
  wire [3:0] hold_nib = margin_r[7:4];
  wire [3:0] setup_nib = margin_r[3:0];
  wire hold_zero = hold_nib == `SRCM_NIB_ZERO;
  wire setup_zero = setup_nib == `SRCM_NIB_ZERO;
  wire setup_low = setup_nib < `SRCM_NIB_MID;
  wire hold_high = hold_nib > `SRCM_NIB_MID;
  reg [1:0] class_nxt;
  always @* begin
    class_nxt = CLS_OK;
    if (hold_zero && setup_zero) begin
      class_nxt = CLS_BOTH;
    end else if (hold_zero && setup_low) begin
      class_nxt = CLS_SETUP;
    end else if (hold_high && setup_zero) begin
      class_nxt = CLS_HOLD;
    end else begin
      class_nxt = CLS_OK;
    end
  end

  // Quick configuration decode
  reg q_ok;
  reg [2:0] q_l;
  reg [3:0] q_m;
  reg [4:0] q_f;
  always @* begin
    q_ok = 1'b1;
    q_l = lanes_o;
    q_m = converters_o;
    q_f = octets_o;
    case (qcfg_r)
      `SRCM_Q_L1M8F16: begin
        q_l = 3'h1;
        q_m = 4'h8;
        q_f = 5'h10;
      end
      `SRCM_Q_L2M8F8: begin
        q_l = 3'h2;
        q_m = 4'h8;
        q_f = 5'h08;
      end
      `SRCM_Q_L2M2F2: begin
        q_l = 3'h2;
        q_m = 4'h2;
        q_f = 5'h02;
      end
      `SRCM_Q_L4M2F1: begin
        q_l = 3'h4;
        q_m = 4'h2;
        q_f = 5'h01;
      end
      default: begin
        q_ok = 1'b0;
      end
    endcase
  end

  // Multiframe length legality, reported only
  reg k_ok;
  always @* begin
    k_ok = (kfrm_r[1:0] == 2'b00) && (kfrm_r <= 6'h20);
    case (octets_o)
      5'h01: k_ok = k_ok && (kfrm_r >= 6'h14);
      5'h02: k_ok = k_ok && (kfrm_r >= 6'h0c);
      5'h04: k_ok = k_ok && (kfrm_r >= 6'h08);
      default: k_ok = k_ok && (kfrm_r >= 6'h04);
    endcase
  end

  // Skip counter and arming
  always @(posedge clk_i) begin
    if (rst_i) begin
      skip_cfg_r <= 5'h00;
      skip_left_r <= 5'h00;
      armed_r <= 1'b0;
    end else if (wr_skip) begin
      skip_cfg_r <= skip_clip;
      skip_left_r <= skip_clip;
      armed_r <= 1'b1;
    end else if (discard) begin
      skip_left_r <= skip_left_r - 5'h01;
    end else if (accept) begin
      armed_r <= ctrl_r[`SRCM_CTRL_CONT];
      skip_left_r <= skip_cfg_r;
    end
  end

  // Alignment strobes, one cycle each
  always @(posedge clk_i) begin
    if (rst_i) begin
      align_clkdiv_o <= 1'b0;
      align_downconv_o <= 1'b0;
      align_sigmon_o <= 1'b0;
      align_framer_o <= 1'b0;
    end else begin
      align_clkdiv_o <= accept & ctrl_r[`SRCM_CTRL_ALN_DIV];
      align_downconv_o <= accept & ctrl_r[`SRCM_CTRL_ALN_DNC];
      align_sigmon_o <= accept & ctrl_r[`SRCM_CTRL_ALN_MON];
      align_framer_o <= accept & ctrl_r[`SRCM_CTRL_ALN_LNK];
    end
  end

  // Margin byte latched on every detected event, armed or skipped alike, class follows
  always @(posedge clk_i) begin
    if (rst_i) begin
      margin_r <= 8'h00;
      class_r <= CLS_OK;
    end else begin
      if (ev) begin
        margin_r <= {hold_cnt, setup_cnt};
      end
      class_r <= class_nxt;
    end
  end

  // Software written configuration and decoded lane setup
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SRCM_CTRL_RST;
      irq_mask_r <= 3'h0;
      qcfg_r <= `SRCM_QCFG_RST;
      kfrm_r <= `SRCM_KFRM_RST;
      link_req_r <= 1'b0;
      lanes_o <= 3'h1;
      converters_o <= 4'h8;
      octets_o <= 5'h10;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= dat_i[7:0];
      end
      if (wr_irq_mask) begin
        irq_mask_r <= dat_i[2:0];
      end
      if (wr_qcfg) begin
        qcfg_r <= dat_i[7:0];
      end
      if (wr_kfrm) begin
        kfrm_r <= dat_i[5:0];
      end
      if (wr_link) begin
        link_req_r <= dat_i[`SRCM_LINK_REQ];
      end
      if (q_ok) begin
        lanes_o <= q_l;
        converters_o <= q_m;
        octets_o <= q_f;
      end
    end
  end

  // Sticky status; a set in the clearing cycle wins
  wire [2:0] irq_clr = wr_irq_stat ? dat_i[2:0] : 3'h0;
  wire class_risk = (class_nxt != CLS_OK) & (class_nxt != class_r);
  wire [2:0] irq_set = {~q_ok, class_risk, accept};
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Sample format and lane rate outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      res_bits_o <= `SRCM_N_CPLX;
      container_bits_o <= `SRCM_NP_BITS;
      frames_per_mf_o <= `SRCM_KFRM_RST;
      low_lane_rate_o <= 1'b0;
    end else begin
      res_bits_o <= link_req_r ? `SRCM_N_REQ : `SRCM_N_CPLX;
      container_bits_o <= `SRCM_NP_BITS;
      frames_per_mf_o <= kfrm_r;
      low_lane_rate_o <= ctrl_r[`SRCM_CTRL_LOW_RATE];
    end
  end

  // Expected converter count for the chosen mode, read back only
  wire [3:0] mode_m = link_req_r ? `SRCM_M_REQ : `SRCM_M_CPLX;

  // Read mux
  reg [31:0] rd;
  always @* begin
    rd = 32'h0;
    case (idx)
      `SRCM_IDX_CTRL: rd = {24'h0, ctrl_r};
      `SRCM_IDX_SKIP: rd = {27'h0, skip_cfg_r};
      `SRCM_IDX_MARGIN: rd = {24'h0, margin_r};
      `SRCM_IDX_IRQ_STAT: rd = {29'h0, irq_stat_r};
      `SRCM_IDX_IRQ_MASK: rd = {29'h0, irq_mask_r};
      `SRCM_IDX_QCFG: rd = {8'h0, converters_o, 3'h0, octets_o,
                            1'b0, lanes_o, qcfg_r};
      `SRCM_IDX_KFRM: rd = {25'h0, k_ok, kfrm_r};
      `SRCM_IDX_STATUS: rd = {20'h0, q_ok, armed_r, class_r,
                              3'h0, skip_left_r};
      `SRCM_IDX_LINK: rd = {24'h0, mode_m, 3'h0, link_req_r};
      default: rd = 32'h0;
    endcase
  end

  // Wishbone answer: ack one cycle after request, data registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o)
        dat_o <= rd;
    end
  end

endmodule

`default_nettype wire

// ===== srcm_top_properties.sv
// Port checker for srcm_top, bound at the foot
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module srcm_chk (
  input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o, sysref_i,
  input wire logic align_clkdiv_o, align_downconv_o,
  input wire logic align_sigmon_o, align_framer_o,
  input wire logic [31:0] dat_o,
  input wire logic [2:0] lanes_o,
  input wire logic [3:0] converters_o,
  input wire logic [4:0] octets_o, res_bits_o, container_bits_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic al = align_clkdiv_o | align_downconv_o |
    align_sigmon_o | align_framer_o;
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence quiet_s; $stable(sysref_i) [*6]; endsequence
  chk_ack_follow: assert property (req_s |=> ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("stray ack");
  chk_rd_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data moved");
  chk_align_single: assert property (al |=> !al)
    else $error("align too long");
  chk_align_quiet: assert property (quiet_s |-> !al)
    else $error("align without event");
  chk_qcfg_legal: assert property (
    {lanes_o, converters_o, octets_o} inside
    {12'h310, 12'h508, 12'h442, 12'h841}) else $error("bad lane setup");
  chk_format: assert property (container_bits_o == 5'h10 &&
    (res_bits_o == 5'h0e || res_bits_o == 5'h09)) else $error("bad format");
endmodule
bind srcm_top srcm_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .sysref_i(sysref_i), .dat_o(dat_o),
  .align_clkdiv_o(align_clkdiv_o), .align_downconv_o(align_downconv_o),
  .align_sigmon_o(align_sigmon_o), .align_framer_o(align_framer_o),
  .lanes_o(lanes_o), .converters_o(converters_o), .octets_o(octets_o),
  .res_bits_o(res_bits_o), .container_bits_o(container_bits_o));
`default_nettype wire

// ===== srcm_refgen.sv
// Reference generator model: one event per pulse call
// Assumes the bench sets pol_i, the idle level of the reference
`timescale 1ns/1ps
`default_nettype none
module srcm_refgen (
  input wire logic clk_i,
  input wire logic pol_i,
  output logic sysref_o = 1'b0,
  output logic [14:0] setup_o = 15'h0,
  output logic [14:0] hold_o = 15'h0
);
  logic busy = 1'b0;
  always @(posedge clk_i) begin
    if (!busy) begin
      sysref_o <= pol_i;
      setup_o <= {15{pol_i}};
      hold_o <= {15{pol_i}};
    end
  end
  task automatic pulse(int s, int h);
    busy = 1'b1;
    @(posedge clk_i);
    sysref_o <= ~pol_i;
    setup_o <= ((15'h1 << s) - 15'h1) ^ {15{pol_i}};
    hold_o <= ((15'h1 << h) - 15'h1) ^ {15{pol_i}};
    repeat (4) @(posedge clk_i);
    busy = 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== srcm_top_tb_top.sv
// Bench for srcm_top with a reference generator and count model
// Assumes srcm_refgen and the bound checker
`timescale 1ns/1ps
`default_nettype none
module srcm_top_tb_top;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, pol = 0;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rv;
  logic [3:0] sel = 0;
  logic [7:0] cw[6] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h08, 8'h40};
  logic [7:0] qc[4] = '{8'h1c, 8'h5b, 8'h49, 8'h88};
  logic [11:0] lmf[4] = '{12'h310, 12'h508, 12'h442, 12'h841};
  logic [7:0] mh[6] = '{8'h03, 8'h58, 8'h8c, 8'h80, 8'hb0, 8'h00};
  logic [9:0] rx[5] = '{10'h120, 10'h121, 10'h128, 10'h131, 10'h3ff};
  int n_errors = 0, checks_done = 0, ac[4] = '{0, 0, 0, 0}, bs[4];
  int sk[3] = '{0, 3, 20};
  wire logic [31:0] rd;
  wire logic ack, sr, irq, llr;
  wire logic [3:0] al, cv;
  wire logic [14:0] st, ht;
  wire logic [2:0] ln;
  wire logic [4:0] oc, rb, cb;
  wire logic [5:0] kf;
  srcm_top i_srcm_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wd), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
    .dat_o(rd), .ack_o(ack), .sysref_i(sr), .setup_taps_i(st),
    .hold_taps_i(ht), .align_clkdiv_o(al[0]), .align_downconv_o(al[1]),
    .align_sigmon_o(al[2]), .align_framer_o(al[3]), .lanes_o(ln),
    .converters_o(cv), .octets_o(oc), .res_bits_o(rb),
    .container_bits_o(cb), .frames_per_mf_o(kf), .low_lane_rate_o(llr),
    .irq_o(irq));
  srcm_refgen i_srcm_refgen (.clk_i(clk_i), .pol_i(pol), .sysref_o(sr),
    .setup_o(st), .hold_o(ht));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    for (int k = 0; k < 4; k++)
      if (al[k] === 1'b1) ac[k]++;
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [9:0] ix, logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, ix, 2'b00, d, 4'hf};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      final_report();
    end
    rv = rd;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic fire(int n, int s, int h);
    bs = ac;
    repeat (n) i_srcm_refgen.pulse(s, h);
    repeat (6) @(posedge clk_i);
  endtask
  function automatic logic [31:0] dv();
    return {8'(ac[3] - bs[3]), 8'(ac[2] - bs[2]),
      8'(ac[1] - bs[1]), 8'(ac[0] - bs[0])};
  endfunction
  function automatic logic [31:0] ex(logic [3:0] c);
    return {7'h0, c[3], 7'h0, c[2], 7'h0, c[1], 7'h0, c[0]};
  endfunction
  function automatic logic [1:0] cls(logic [3:0] h, logic [3:0] s);
    if (h == 4'h0 && s == 4'h0) return 2'h3;
    if (h == 4'h0 && s < 4'h8) return 2'h1;
    if (s == 4'h0 && h > 4'h8) return 2'h2;
    return 2'h0;
  endfunction
  initial begin
    logic [7:0] m;
    rv = $urandom(32'h1b9be1a7);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1, 10'h128, 32'hff);
    for (int i = 0; i < 5; i++) begin
      bus(0, rx[i], 0);
      chk("reset value", (i == 0) ? 32'h78 : 32'h0, rv);
    end
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      bus(1, 10'h120, {24'h0, cw[i]});
      pol <= cw[i][0];
      bus(1, 10'h121, 0);
      fire(1, 4, 8);
      chk("align", ex(cw[i][6:3]), dv());
    end
    $display("align test done");
    bus(1, 10'h120, 32'h7c);
    bus(1, 10'h121, 0);
    for (int i = 0; i < 10; i++) begin
      m = (i < 6) ? mh[i] : 8'($urandom);
      fire(1, m[3:0], m[7:4]);
      bus(0, 10'h128, 0);
      chk("margin", {24'h0, m}, rv);
      bus(0, 10'h134, 0);
      chk("class", cls(m[7:4], m[3:0]), rv[9:8]);
    end
    bus(1, 10'h120, 32'h78);
    for (int i = 0; i < 3; i++) begin
      bus(1, 10'h121, sk[i]);
      fire((sk[i] > 16) ? 16 : sk[i], 2, 8);
      chk("skipped", 0, dv());
      fire(2, 2, 8);
      chk("aligned", ex(4'hf), dv());
    end
    $display("margin and skip tests done");
    for (int i = 0; i < 4; i++) begin
      bus(1, 10'h132, {24'h0, qc[i]});
      bus(1, 10'h120, {24'h0, i[0], 7'h78});
      bus(1, 10'h135, i / 2);
      bus(1, 10'h133, 32'h20);
      repeat (2) @(posedge clk_i);
      rv = {3'h0, lmf[i], (i < 2) ? 5'h0e : 5'h09, 5'h10, 6'h20, i[0]};
      chk("link", rv, {ln, cv, oc, rb, cb, kf, llr});
    end
    bus(1, 10'h130, 32'h7);
    bus(1, 10'h132, 32'h77);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 0, irq);
    bus(1, 10'h131, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 1, irq);
    bus(1, 10'h132, 32'h49);
    bus(1, 10'h130, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 0, irq);
    $display("config test done");
    final_report();
  end
endmodule
`default_nettype wire
